//--- vsp_i2c_vid_slave_port.sv
// I2C target that receives, checks, holds and returns the voltage-identification byte
// Operation
// - Acts only as I2C target; works at 100 kbps and 400 kbps bus rates.
// - Stores one written byte in the holding buffer that sets output voltage.
// - Master can read back the holding buffer contents over the bus.
// - When enabled, checks the seven-bit address after every START and repeated START.
// - On address match, pulls SDA low during the ninth SCL pulse.
// - On address mismatch, does nothing and leaves SDA released.
// - After mismatch, ignores remaining bits until the next START.
// - A valid new command takes effect within 27 SCL periods.
// - Bit after the address selects direction: zero write, one read.
// - In a write, shifts in the data byte after the address ACK and checks it.
// - Valid byte is acknowledged and loaded into the holding buffer.
// - Invalid byte gets no acknowledge; holding buffer stays unchanged.
// - In a read, sends the buffer MSB first, one bit per SCL clock.
// - After eight read bits and STOP, returns to idle regardless of master ACK.
// - Power-good rises a fixed 4 ms soft-start interval after enable.
// - Bit 7 must equal XNOR of bits 6..0; mismatch is invalid; returned on read.
// - After reset the seven-bit voltage code holds the default pattern.
`timescale 1ns/1ns

module vsp_i2c_vid_slave_port
    import vsp_pkg::*;
#(
    parameter int unsigned SOFT_START_CYCLES = SOFT_START_CYCLES_DEF,
    parameter logic [6:0]  DEVICE_ADDR       = DEVICE_ADDR_DEF
) (
    // System clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // I2C link; SCL also clocks the receive shifter
    input  wire logic       scl_clk,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Regulator side
    input  wire logic       enable,
    output logic [7:0]      voltage_id_code,
    output logic            vid_updated,
    output logic            power_good_out
);

    // Parity check of a voltage byte
    function automatic logic byte_valid(input logic [7:0] value);
        byte_valid = (value[7] == ~^value[6:0]);
    endfunction

    // ------------------------------------------------------------------
    // Link domain: SDA sampled on SCL rise, as the protocol defines
    // ------------------------------------------------------------------
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;

    always_comb begin
        next_rx_shift = {rx_shift[6:0], sda_in};
    end

    always_ff @(posedge scl_clk) begin
        rx_shift <= next_rx_shift;
    end

    // ------------------------------------------------------------------
    // Pin and word synchronisers
    // ------------------------------------------------------------------
    // Shifter word is only read one stage after the SCL edge is seen, so it
    // has been still for at least one cycle and cannot be caught mid-change.
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_dly;
    logic [2:0] pin_last;
    logic [7:0] rx_meta;
    logic [7:0] rx_sync;
    logic [2:0] next_pin_meta;
    logic [2:0] next_pin_sync;
    logic [2:0] next_pin_dly;
    logic [2:0] next_pin_last;
    logic [7:0] next_rx_meta;
    logic [7:0] next_rx_sync;

    always_comb begin
        next_pin_meta = {enable, sda_in, scl_clk};
        next_pin_sync = pin_meta;
        next_pin_dly  = pin_sync;
        next_pin_last = pin_dly;
        next_rx_meta  = rx_shift;
        next_rx_sync  = rx_meta;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
            pin_dly  <= PIN_IDLE;
            pin_last <= PIN_IDLE;
            rx_meta  <= BYTE_RESET;
            rx_sync  <= BYTE_RESET;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
            pin_dly  <= next_pin_dly;
            pin_last <= next_pin_last;
            rx_meta  <= next_rx_meta;
            rx_sync  <= next_rx_sync;
        end
    end

    // ------------------------------------------------------------------
    // Bus event detection
    // ------------------------------------------------------------------
    // 250 MHz oversampling leaves hundreds of samples per SCL phase even at
    // the fast rate, so edge order is always resolved correctly.
    vsp_bus_ev_t ev;
    logic        bus_enabled;

    always_comb begin
        bus_enabled = pin_dly[PIN_EN];
        ev.scl_rise = pin_dly[PIN_SCL] & ~pin_last[PIN_SCL];
        ev.scl_fall = ~pin_dly[PIN_SCL] & pin_last[PIN_SCL];
        ev.start    = pin_last[PIN_SDA] & ~pin_dly[PIN_SDA]
                    & pin_dly[PIN_SCL] & pin_last[PIN_SCL];
        ev.stop     = ~pin_last[PIN_SDA] & pin_dly[PIN_SDA]
                    & pin_dly[PIN_SCL] & pin_last[PIN_SCL];
    end

    // ------------------------------------------------------------------
    // Bus state machine and holding buffer
    // ------------------------------------------------------------------
    vsp_state_t state;
    vsp_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic       dir;
    logic       next_dir;
    logic [7:0] tx_byte;
    logic [7:0] next_tx_byte;
    logic [7:0] next_vid;
    logic       next_vid_updated;
    logic       next_sda_oe;
    logic [3:0] tx_index;

    always_comb begin
        next_state       = state;
        next_bit_cnt     = bit_cnt;
        next_dir         = dir;
        next_tx_byte     = tx_byte;
        next_vid         = voltage_id_code;
        next_vid_updated = 1'b0;
        next_sda_oe      = sda_oe;
        tx_index         = BYTE_BITS - 4'h1 - bit_cnt;
        if (!bus_enabled || ev.stop) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (ev.start) begin
            // Repeated START restarts address matching from any state
            next_state   = ST_ADDR;
            next_bit_cnt = BIT_CNT_RESET;
            next_sda_oe  = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                ST_ADDR: begin
                    if (ev.scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == BYTE_BITS - 4'h1) begin
                            if (rx_sync[7:1] == DEVICE_ADDR) begin
                                next_state = ST_ADDR_ACK;
                                next_dir   = rx_sync[0];
                            end else begin
                                next_state = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        next_bit_cnt = BIT_CNT_RESET;
                        // First fall starts the ACK bit, the second ends it
                        if (!sda_oe) begin
                            next_sda_oe = 1'b1;
                        end else if (dir == DIR_READ) begin
                            // First read bit goes out on the falling edge that ends ACK
                            next_state   = ST_RD_DATA;
                            next_tx_byte = voltage_id_code;
                            next_sda_oe  = ~voltage_id_code[7];
                        end else begin
                            next_state  = ST_WR_DATA;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_WR_DATA: begin
                    if (ev.scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == BYTE_BITS - 4'h1) begin
                            if (byte_valid(rx_sync)) begin
                                // Loaded at the eighth data bit, well inside 27 SCL periods
                                next_state       = ST_WR_ACK;
                                next_vid         = rx_sync;
                                next_vid_updated = 1'b1;
                            end else begin
                                // Buffer untouched and no ACK; master must retry
                                next_state = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (ev.scl_fall) begin
                        if (!sda_oe) begin
                            next_sda_oe = 1'b1;
                        end else begin
                            // Only one byte is held; further bytes are not acknowledged
                            next_sda_oe = 1'b0;
                            next_state  = ST_IGNORE;
                        end
                    end
                end
                ST_RD_DATA: begin
                    if (ev.scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (ev.scl_fall) begin
                        if (bit_cnt == BYTE_BITS) begin
                            // Master ACK or NACK is not examined
                            next_sda_oe = 1'b0;
                            next_state  = ST_IGNORE;
                        end else begin
                            next_sda_oe = ~tx_byte[tx_index[2:0]];
                        end
                    end
                end
                ST_IGNORE: begin
                    // Stays until START or STOP; nothing is answered
                    next_sda_oe = 1'b0;
                end
                default: begin
                    next_state  = ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state           <= ST_IDLE;
            bit_cnt         <= BIT_CNT_RESET;
            dir             <= DIR_WRITE;
            tx_byte         <= BYTE_RESET;
            voltage_id_code <= VID_DEFAULT;
            vid_updated     <= 1'b0;
            sda_oe          <= 1'b0;
            sda_out         <= 1'b0;
        end else begin
            state           <= next_state;
            bit_cnt         <= next_bit_cnt;
            dir             <= next_dir;
            tx_byte         <= next_tx_byte;
            voltage_id_code <= next_vid;
            vid_updated     <= next_vid_updated;
            sda_oe          <= next_sda_oe;
            // Open drain: the pin is only ever pulled low
            sda_out         <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Soft start and power good
    // ------------------------------------------------------------------
    // Count saturates so power good holds while enable stays high.
    logic [31:0] ss_count;
    logic [31:0] next_ss_count;
    logic        next_power_good;

    always_comb begin
        next_ss_count   = ss_count;
        next_power_good = 1'b0;
        // Enable low restarts the interval from zero
        if (!pin_dly[PIN_EN]) begin
            next_ss_count = COUNT_RESET;
        end else if (ss_count != SOFT_START_CYCLES) begin
            next_ss_count = ss_count + 32'h1;
        end else begin
            next_power_good = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ss_count       <= COUNT_RESET;
            power_good_out <= 1'b0;
        end else begin
            ss_count       <= next_ss_count;
            power_good_out <= next_power_good;
        end
    end

endmodule

//--- vsp_pkg.sv
// Shared constants and types for the voltage-code I2C slave port
package vsp_pkg;

    // System clock and soft-start timing
    localparam int unsigned CLOCK_PERIOD_NS   = 4;
    localparam int unsigned SOFT_START_MS     = 4;
    localparam int unsigned NS_PER_MS         = 1000000;
    localparam int unsigned SOFT_START_CYCLES_DEF =
        (SOFT_START_MS * NS_PER_MS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Own target address; value is arbitrary
    localparam logic [6:0] DEVICE_ADDR_DEF = 7'h2a;

    // Byte framing
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic       DIR_WRITE     = 1'h0;
    localparam logic       DIR_READ      = 1'h1;

    // Holding buffer default: bit 7 is the xnor of bits 6..0
    localparam logic [6:0] VID_DEFAULT_CODE = 7'h32;
    localparam logic [7:0] VID_DEFAULT      = {~^VID_DEFAULT_CODE, VID_DEFAULT_CODE};

    // Synchronised pin vector: bit positions and idle levels
    localparam int unsigned PIN_SCL  = 0;
    localparam int unsigned PIN_SDA  = 1;
    localparam int unsigned PIN_EN   = 2;
    localparam logic [2:0]  PIN_IDLE = 3'h3;

    // Other reset values
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    // Bus state machine, one-hot
    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_WR_DATA  = 8'h08,
        ST_WR_ACK   = 8'h10,
        ST_RD_DATA  = 8'h20,
        ST_IGNORE   = 8'h40
    } vsp_state_t;

    // Bus events seen in the system domain
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } vsp_bus_ev_t;

endpackage

//--- vsp_port_asserts.sv
// Assertion checker for the voltage-code I2C slave port
`timescale 1ns/1ns
module vsp_port_asserts #(
    parameter int unsigned SOFT_START_CYCLES = vsp_pkg::SOFT_START_CYCLES_DEF
) (
    // System side
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       enable,
    // Link
    input wire logic       scl_clk,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // Regulator side
    input wire logic [7:0] voltage_id_code,
    input wire logic       vid_updated,
    input wire logic       power_good_out
);
    logic [31:0] en_run;
    logic [31:0] next_en_run;
    // Saturates so a long run never wraps back to zero
    always_comb begin
        next_en_run = enable ? en_run + 32'h1 : 32'h0;
        if (en_run == 32'hffff_ffff) next_en_run = en_run;
    end
    always_ff @(posedge clock) begin
        en_run <= reset ? 32'h0 : next_en_run;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence s_en_low;
        !enable [*8];
    endsequence
    property p_reset_out;
        $fell(reset) |-> voltage_id_code == 8'h32 && !sda_oe && !power_good_out && !vid_updated;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset values wrong");
    property p_idle_release;
        s_en_low |-> !sda_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("sda driven");
    property p_open_drain;
        sda_oe |-> !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    property p_sda_scl_low;
        $changed(sda_oe) && !$past(reset) |-> !scl_clk;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved, scl high");
    property p_buf_hold;
        $changed(voltage_id_code) && !$past(reset) |-> vid_updated || $past(vid_updated);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("buffer changed unasked");
    property p_parity;
        vid_updated |=> voltage_id_code[7] == ~^voltage_id_code[6:0];
    endproperty
    a_parity: assert property (p_parity) else $error("bad parity loaded");
    property p_pulse;
        vid_updated |=> !vid_updated;
    endproperty
    a_pulse: assert property (p_pulse) else $error("update pulse too long");
    property p_pg_off;
        s_en_low |-> !power_good_out;
    endproperty
    a_pg_off: assert property (p_pg_off) else $error("power good while off");
    property p_pg_early;
        $rose(power_good_out) |-> en_run >= SOFT_START_CYCLES;
    endproperty
    a_pg_early: assert property (p_pg_early) else $error("power good early");
    property p_pg_late;
        en_run >= SOFT_START_CYCLES + 12 |-> power_good_out;
    endproperty
    a_pg_late: assert property (p_pg_late) else $error("power good late");
endmodule

bind vsp_i2c_vid_slave_port vsp_port_asserts #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) u_chk (
    .clock(clock), .reset(reset), .enable(enable), .scl_clk(scl_clk), .sda_out(sda_out),
    .sda_oe(sda_oe), .voltage_id_code(voltage_id_code), .vid_updated(vid_updated),
    .power_good_out(power_good_out)
);

//--- vsp_i2c_master.sv
// Behavioural I2C master driving the link
`timescale 1ns/1ns
module vsp_i2c_master (
    // Link
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // Quarter SCL period in ns; 625 is 400 kbps
    int q = 625;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Sda only moves mid-low so no false start or stop
    task automatic start();
        #q sda_low = 1'b0;
        #q scl = 1'b1;
        #q sda_low = 1'b1;
        #q scl = 1'b0;
    endtask
    task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #q sda_low = ~tx[i];
            #q scl = 1'b1;
            #q rx[i] = sda;
            #q scl = 1'b0;
        end
    endtask
    task automatic stop();
        #q sda_low = 1'b1;
        #q scl = 1'b1;
        #q sda_low = 1'b0;
        #q;
    endtask
endmodule

//--- vsp_i2c_vid_slave_port_bench.sv
// Self-checking bench for the voltage-code I2C slave port
`timescale 1ns/1ns
module vsp_i2c_vid_slave_port_bench;
    localparam int unsigned SS    = 50;
    localparam int unsigned LIMIT = 100000;
    localparam logic [6:0]  ADDR  = 7'h2a;
    logic       clock  = 1'b0;
    logic       reset  = 1'b1;
    logic       enable = 1'b0;
    logic       scl_clk;
    logic       m_low;
    logic       sda_in;
    logic       sda_out;
    logic       sda_oe;
    logic [7:0] voltage_id_code;
    logic       vid_updated;
    logic       power_good_out;
    int         n_fail = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         n_upd = 0;
    logic [7:0] exp_vid;
    // Open-drain wire with pull-up
    assign sda_in = ~((sda_oe & ~sda_out) | m_low);
    vsp_i2c_vid_slave_port #(.SOFT_START_CYCLES(SS), .DEVICE_ADDR(ADDR)) dut (
        .clock(clock), .reset(reset), .scl_clk(scl_clk), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .enable(enable),
        .voltage_id_code(voltage_id_code), .vid_updated(vid_updated),
        .power_good_out(power_good_out)
    );
    vsp_i2c_master m (.scl(scl_clk), .sda_low(m_low), .sda(sda_in));
    initial begin
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            summarize();
        end
    end
    // Update pulses, counted mid-cycle where they stand
    always @(negedge clock) begin
        if (vid_updated === 1'b1)
            n_upd++;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    function automatic logic [7:0] par(input logic [6:0] c);
        return {~^c, c};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_power_good();
        int n;
        n = 0;
        repeat (10) @(negedge clock);
        enable = 1'b1;
        while (power_good_out !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("soft start", 8'h01, {7'h00, n >= SS && n <= SS + 8});
        $display("test power good done");
    endtask
    task automatic do_write(input logic [7:0] d, input logic ok);
        logic [8:0] rx;
        int         upd0;
        upd0 = n_upd;
        m.start();
        m.byte9({ADDR, 1'b0, 1'b1}, rx);
        chk("addr ack", 8'h01, {7'h00, ~rx[0]});
        m.byte9({d, 1'b1}, rx);
        chk("data ack", {7'h00, ok}, {7'h00, ~rx[0]});
        @(negedge clock);
        if (ok)
            exp_vid = d;
        chk("buffer", exp_vid, voltage_id_code);
        chk("update pulse", {7'h00, ok}, 8'(n_upd - upd0));
        m.stop();
        $display("test write %h done", d);
    endtask
    task automatic t_mismatch_read(input logic [7:0] exp);
        logic [8:0] rx;
        m.start();
        m.byte9({ADDR ^ 7'h01, 1'b0, 1'b1}, rx);
        chk("foreign ack", 8'h00, {7'h00, ~rx[0]});
        m.byte9({par(7'h01), 1'b1}, rx);
        chk("ignored ack", 8'h00, {7'h00, ~rx[0]});
        m.start();
        m.byte9({ADDR, 1'b1, 1'b1}, rx);
        chk("read ack", 8'h01, {7'h00, ~rx[0]});
        // Read byte at 100 kbps; the rate may change between bytes
        m.q = 2500;
        m.byte9(9'h1ff, rx);
        chk("read data", exp, rx[8:1]);
        m.q = 625;
        m.stop();
        @(negedge clock);
        chk("released", 8'h00, {7'h00, sda_oe});
        chk("buffer kept", exp, voltage_id_code);
        $display("test mismatch and read done");
    endtask
    // Fresh read, as a master does when it doubts a result
    task automatic t_fresh_read(input logic [7:0] exp);
        logic [8:0] rx;
        m.start();
        m.byte9({ADDR, 1'b1, 1'b1}, rx);
        chk("reread ack", 8'h01, {7'h00, ~rx[0]});
        m.byte9(9'h1ff, rx);
        chk("reread data", exp, rx[8:1]);
        m.stop();
        $display("test fresh read done");
    endtask
    initial begin
        repeat (5) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        exp_vid = par(7'b0110010);
        chk("default code", exp_vid, voltage_id_code);
        chk("sda reset", 8'h00, {7'h00, sda_oe});
        chk("sda out", 8'h00, {7'h00, sda_out});
        $display("test reset done");
        t_power_good();
        do_write(8'h55, 1'b0);
        do_write(par(7'h55), 1'b1);
        t_mismatch_read(par(7'h55));
        t_fresh_read(par(7'h55));
        summarize();
    end
endmodule
